//--- shared/lpdc_pkg.sv
// Purpose: Constants for the luma peaking, noise reduction and comb configuration block
// Assumes: 8-bit luma samples, one sample per clock when valid
// Notes:   Register offsets are the byte addresses of the host register port
package lpdc_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] LPDC_OFS_SPLIT  = 8'h19;
   localparam logic [7:0] LPDC_OFS_NCOMB  = 8'h38;
   localparam logic [7:0] LPDC_OFS_PCOMB  = 8'h39;
   localparam logic [7:0] LPDC_OFS_NREN   = 8'h4D;
   localparam logic [7:0] LPDC_OFS_PEAK   = 8'hFB;
   localparam logic [7:0] LPDC_OFS_NTH2   = 8'hFC;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int LPDC_NSF_LSB  = 2;
   localparam int LPDC_PSF_LSB  = 0;
   localparam int LPDC_TAP_LSB  = 6;
   localparam int LPDC_CCM_LSB  = 3;
   localparam int LPDC_YCM_LSB  = 0;
   localparam int LPDC_NREN_BIT = 5;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [1:0] LPDC_RST_NSF  = 2'h0;
   localparam logic [1:0] LPDC_RST_PSF  = 2'h1;
   localparam logic [1:0] LPDC_RST_NTAP = 2'h2;
   localparam logic [1:0] LPDC_RST_PTAP = 2'h3;
   localparam logic [2:0] LPDC_RST_MODE = 3'h0;
   localparam logic [7:0] LPDC_RST_PEAK = 8'h40;
   localparam logic [7:0] LPDC_RST_NTH2 = 8'h04;
   localparam logic       LPDC_RST_NREN = 1'b1;
   // Unity peaking gain, 2.6 fixed point
   localparam logic [7:0] LPDC_UNITY    = 8'h40;
   localparam int         LPDC_GAIN_SH  = 6;
   // ------------------------------------------------------------
   // Comb mode codes
   // ------------------------------------------------------------
   localparam logic [2:0] LPDC_CM_ADAPT  = 3'h0;
   localparam logic [2:0] LPDC_CM_OFF    = 3'h4;
   localparam logic [2:0] LPDC_CM_TOP    = 3'h5;
   localparam logic [2:0] LPDC_CM_ALL    = 3'h6;
   localparam logic [2:0] LPDC_CM_BOTTOM = 3'h7;
   // Video standard codes from the standard detector or manual setting
   typedef enum logic [3:0] {
      LPDC_STD_NTSC_M, LPDC_STD_NTSC_J, LPDC_STD_PAL_BGHID, LPDC_STD_PAL_M,
      LPDC_STD_PAL_CN, LPDC_STD_PAL_60, LPDC_STD_NTSC_443, LPDC_STD_SECAM
   } lpdc_std_e;
endpackage

//--- rtl/lpdc_peak_core.sv
// Purpose: Mid-band luma peaking followed by the second noise stage
// Assumes: Gain in 2.6 fixed point, one sample per valid
// Notes:   Three-tap band-pass centred near a quarter of the sample rate
`timescale 1ns/1ps
`default_nettype none
module lpdc_peak_core
   import lpdc_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_luma,
   input  wire logic [7:0]   gain,
   input  wire logic [7:0]   thresh,
   input  wire logic         nr_en,
   output logic [W-1:0]      out_luma
);
   // ------------------------------------------------------------
   // Tap line
   // ------------------------------------------------------------
   logic [W-1:0] t1_q, t1_d, t2_q, t2_d, t3_q, t3_d, t4_q, t4_d;
   logic [W-1:0] hold_q, hold_d, out_q, out_d;
   logic signed [W+1:0]  band;
   logic signed [W+10:0] boost, peaked;
   logic [W-1:0]         sat;
   logic [W:0]           edge_mag;

   always_comb begin
      t1_d   = in_valid ? in_luma : t1_q;
      t2_d   = in_valid ? t1_q : t2_q;
      t3_d   = in_valid ? t2_q : t3_q;
      t4_d   = in_valid ? t3_q : t4_q;
      // Neighbours two samples away put the peak at a quarter rate, not Nyquist
      band   = $signed({2'b00, t2_q}) - ($signed({2'b00, in_luma}) >>> 1)
               - ($signed({2'b00, t4_q}) >>> 1);
      // Gain scales only the band, unity leaves luma untouched
      boost  = (band * $signed({1'b0, gain})) >>> LPDC_GAIN_SH;
      peaked = $signed({11'h000, t2_q}) + boost - (W+11)'(band);
      if (peaked < 0) sat = '0;
      else if (peaked > $signed({11'h000, {W{1'b1}}})) sat = '1;
      else sat = peaked[W-1:0];
      // Second noise stage works on the peaked luma, own threshold
      edge_mag = (sat > hold_q) ? {1'b0, sat - hold_q} : {1'b0, hold_q - sat};
      hold_d = hold_q;
      out_d  = out_q;
      if (in_valid) begin
         if (nr_en && edge_mag <= {1'b0, thresh}) begin
            out_d = hold_q;        // Small step is noise
         end else begin
            out_d  = sat;          // Bypass skips only the noise stage
            hold_d = sat;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         t1_q   <= '0;
         t2_q   <= '0;
         t3_q   <= '0;
         t4_q   <= '0;
         hold_q <= '0;
         out_q  <= '0;
      end else begin
         t1_q   <= t1_d;
         t2_q   <= t2_d;
         t3_q   <= t3_d;
         t4_q   <= t4_d;
         hold_q <= hold_d;
         out_q  <= out_d;
      end
   end
   assign out_luma = out_q;
endmodule
`default_nettype wire

//--- rtl/lpdc_top.sv
// Purpose: Register port, standard selection and line-coherent comb settings
// Assumes: Host writes registers through a byte-wide address/data strobe port
// Notes:   Comb settings take effect only at the next line start
//
// Contract
// - Gain 0x40 passes luma unchanged
// - Peaking acts around 3 MHz band
// - Second noise stage follows peaking, own threshold
// - Threshold resets 0x04, edges up to and equal to it removed
// - Comb set follows detected or manual standard
// - NTSC set for NTSC M and J
// - PAL set for PAL variants, NTSC 4.43
// - NTSC split select, reset narrow
// - PAL split select, reset medium
// - NTSC taps 01/10/11, never write 00
// - NTSC chroma mode decode, reset adaptive
// - NTSC line counts per mode and taps
// - NTSC luma comb mode decode
// - PAL taps 01/10/11, reset 11
// - PAL chroma mode decode, reset adaptive
// - PAL line counts per mode and taps
// - Clearing the enable bit bypasses the second noise stage
`timescale 1ns/1ps
`default_nettype none
module lpdc_top
   import lpdc_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   input  wire logic [7:0]   reg_addr,
   input  wire logic [7:0]   reg_wdata,
   output logic [7:0]        reg_rdata,
   input  wire logic [3:0]   video_std,
   input  wire logic         line_start,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_luma,
   output logic [W-1:0]      out_luma,
   output logic              out_valid,
   output logic              comb_is_pal,
   output logic [1:0]        split_sel,
   output logic [2:0]        chroma_lines,
   output logic              chroma_adaptive,
   output logic              chroma_comb_off,
   output logic [1:0]        chroma_line_sel,
   output logic [2:0]        luma_lines,
   output logic              luma_adaptive,
   output logic              luma_comb_off,
   output logic [1:0]        luma_line_sel
);
   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [1:0] nsf_q, nsf_d, psf_q, psf_d, ntap_q, ntap_d, ptap_q, ptap_d;
   logic [2:0] nccm_q, nccm_d, nycm_q, nycm_d, pccm_q, pccm_d;
   logic [7:0] peak_q, peak_d, nth2_q, nth2_d, rdata_q, rdata_d;
   logic       nren_q, nren_d;

   function automatic logic [1:0] keep_tap(input logic [1:0] nv, input logic [1:0] ov);
      // Code 00 is not a legal tap count, so keep the old value
      return (nv == 2'h0) ? ov : nv;
   endfunction

   always_comb begin
      nsf_d  = nsf_q;
      psf_d  = psf_q;
      ntap_d = ntap_q;
      ptap_d = ptap_q;
      nccm_d = nccm_q;
      nycm_d = nycm_q;
      pccm_d = pccm_q;
      peak_d = peak_q;
      nth2_d = nth2_q;
      nren_d = nren_q;
      if (reg_wr) begin
         case (reg_addr)
            LPDC_OFS_SPLIT: begin
               nsf_d = reg_wdata[LPDC_NSF_LSB +: 2];
               psf_d = reg_wdata[LPDC_PSF_LSB +: 2];
            end
            LPDC_OFS_NCOMB: begin
               ntap_d = keep_tap(reg_wdata[LPDC_TAP_LSB +: 2], ntap_q);
               nccm_d = reg_wdata[LPDC_CCM_LSB +: 3];
               nycm_d = reg_wdata[LPDC_YCM_LSB +: 3];
            end
            LPDC_OFS_PCOMB: begin
               ptap_d = keep_tap(reg_wdata[LPDC_TAP_LSB +: 2], ptap_q);
               pccm_d = reg_wdata[LPDC_CCM_LSB +: 3];
            end
            LPDC_OFS_NREN: nren_d = reg_wdata[LPDC_NREN_BIT];
            LPDC_OFS_PEAK: peak_d = reg_wdata;
            LPDC_OFS_NTH2: nth2_d = reg_wdata;
            default: ;
         endcase
      end
      rdata_d = rdata_q;
      if (reg_rd) begin
         case (reg_addr)
            LPDC_OFS_SPLIT: rdata_d = {4'h0, nsf_q, psf_q};
            LPDC_OFS_NCOMB: rdata_d = {ntap_q, nccm_q, nycm_q};
            LPDC_OFS_PCOMB: rdata_d = {ptap_q, pccm_q, 3'h0};
            LPDC_OFS_NREN:  rdata_d = {2'h0, nren_q, 5'h00};
            LPDC_OFS_PEAK:  rdata_d = peak_q;
            LPDC_OFS_NTH2:  rdata_d = nth2_q;
            default:        rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nsf_q   <= LPDC_RST_NSF;
         psf_q   <= LPDC_RST_PSF;
         ntap_q  <= LPDC_RST_NTAP;
         ptap_q  <= LPDC_RST_PTAP;
         nccm_q  <= LPDC_RST_MODE;
         nycm_q  <= LPDC_RST_MODE;
         pccm_q  <= LPDC_RST_MODE;
         peak_q  <= LPDC_RST_PEAK;
         nth2_q  <= LPDC_RST_NTH2;
         nren_q  <= LPDC_RST_NREN;
         rdata_q <= 8'h00;
      end else begin
         nsf_q   <= nsf_d;
         psf_q   <= psf_d;
         ntap_q  <= ntap_d;
         ptap_q  <= ptap_d;
         nccm_q  <= nccm_d;
         nycm_q  <= nycm_d;
         pccm_q  <= pccm_d;
         peak_q  <= peak_d;
         nth2_q  <= nth2_d;
         nren_q  <= nren_d;
         rdata_q <= rdata_d;
      end
   end
   assign reg_rdata = rdata_q;

   // ------------------------------------------------------------
   // Comb set selection and decode
   // ------------------------------------------------------------
   typedef struct packed {
      logic       pal;
      logic [1:0] split;
      logic [2:0] c_lines;
      logic       c_adapt;
      logic       c_off;
      logic [1:0] c_sel;
      logic [2:0] y_lines;
      logic       y_adapt;
      logic       y_off;
      logic [1:0] y_sel;
   } lpdc_comb_s;

   // Lines used by a chroma comb for a mode and tap code
   function automatic logic [2:0] comb_lines(input logic [2:0] m, input logic [1:0] t);
      logic [2:0] base;
      base = 3'(t) + 3'h1;
      case (m)
         LPDC_CM_TOP, LPDC_CM_BOTTOM: comb_lines = base;        // 2/3/4
         LPDC_CM_ADAPT, LPDC_CM_ALL:  comb_lines = base + 3'h1; // 3/4/5
         default:                     comb_lines = 3'h0;
      endcase
   endfunction

   // Line set: 0 all, 1 top, 2 bottom
   function automatic logic [1:0] line_sel(input logic [2:0] m);
      case (m)
         LPDC_CM_TOP:    line_sel = 2'h1;
         LPDC_CM_BOTTOM: line_sel = 2'h2;
         default:        line_sel = 2'h0;
      endcase
   endfunction

   logic       is_pal;
   logic [2:0] c_mode;
   logic [1:0] c_tap;
   lpdc_comb_s live, act_q, act_d;

   always_comb begin
      // NTSC set only for M and J
      is_pal = !(video_std == LPDC_STD_NTSC_M || video_std == LPDC_STD_NTSC_J);
      c_mode = is_pal ? pccm_q : nccm_q;
      c_tap  = is_pal ? ptap_q : ntap_q;
      live.pal     = is_pal;
      live.split   = is_pal ? psf_q : nsf_q;
      // Chroma decode
      live.c_lines = comb_lines(c_mode, c_tap);
      live.c_adapt = (c_mode == LPDC_CM_ADAPT);
      live.c_off   = (c_mode == LPDC_CM_OFF) || (c_mode[2] == 1'b0 && c_mode != LPDC_CM_ADAPT);
      live.c_sel   = line_sel(c_mode);
      // Luma comb: three lines adaptive/all, two for top/bottom
      live.y_lines = (nycm_q == LPDC_CM_TOP || nycm_q == LPDC_CM_BOTTOM) ? 3'h2 :
                     (nycm_q == LPDC_CM_ADAPT || nycm_q == LPDC_CM_ALL) ? 3'h3 : 3'h0;
      live.y_adapt = (nycm_q == LPDC_CM_ADAPT);
      live.y_off   = (live.y_lines == 3'h0);
      live.y_sel   = line_sel(nycm_q);
      // Mid-line changes would split a line between settings
      act_d = line_start ? live : act_q;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         act_q <= '0;
      end else begin
         act_q <= act_d;
      end
   end

   assign comb_is_pal     = act_q.pal;
   assign split_sel       = act_q.split;
   assign chroma_lines    = act_q.c_lines;
   assign chroma_adaptive = act_q.c_adapt;
   assign chroma_comb_off = act_q.c_off;
   assign chroma_line_sel = act_q.c_sel;
   assign luma_lines      = act_q.y_lines;
   assign luma_adaptive   = act_q.y_adapt;
   assign luma_comb_off   = act_q.y_off;
   assign luma_line_sel   = act_q.y_sel;

   // ------------------------------------------------------------
   // Luma path
   // ------------------------------------------------------------
   logic [1:0] fill_q, fill_d;
   logic       ovld_q, ovld_d;
   always_comb begin
      fill_d = in_valid ? {fill_q[0], 1'b1} : fill_q;
      // Core only advances on valid samples, so a fixed delay would mark stale data
      ovld_d = in_valid && fill_q[1];
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fill_q <= 2'h0;
         ovld_q <= 1'b0;
      end else begin
         fill_q <= fill_d;
         ovld_q <= ovld_d;
      end
   end
   assign out_valid = ovld_q;

   lpdc_peak_core #(.W(W)) u_core (
      .clk      (clk),
      .rstn     (rstn),
      .in_valid (in_valid),
      .in_luma  (in_luma),
      .gain     (peak_q),
      .thresh   (nth2_q),
      .nr_en    (nren_q),
      .out_luma (out_luma)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_line_hold;
      @(posedge clk) disable iff (!rstn) !line_start |=> $stable(act_q);
   endproperty
   a_line_hold: assert property (p_line_hold) else $error("comb setting moved mid line");

   property p_ntsc_sel;
      @(posedge clk) disable iff (!rstn)
         line_start && video_std == LPDC_STD_NTSC_M |=> !comb_is_pal;
   endproperty
   a_ntsc_sel: assert property (p_ntsc_sel) else $error("NTSC M not on NTSC set");

   property p_pal_sel;
      @(posedge clk) disable iff (!rstn)
         line_start && video_std == LPDC_STD_NTSC_443 |=> comb_is_pal;
   endproperty
   a_pal_sel: assert property (p_pal_sel) else $error("NTSC 4.43 not on PAL set");

   property p_tap_keep;
      @(posedge clk) disable iff (!rstn)
         reg_wr && reg_addr == LPDC_OFS_NCOMB && reg_wdata[7:6] == 2'h0 |=> $stable(ntap_q);
   endproperty
   a_tap_keep: assert property (p_tap_keep) else $error("illegal tap code stored");

   property p_fix_lines;
      @(posedge clk) disable iff (!rstn)
         line_start && c_mode == LPDC_CM_TOP && c_tap == 2'h3 |=> chroma_lines == 3'h4;
   endproperty
   a_fix_lines: assert property (p_fix_lines) else $error("fixed top line count wrong");

   property p_adapt_lines;
      @(posedge clk) disable iff (!rstn)
         line_start && c_mode == LPDC_CM_ADAPT && c_tap == 2'h1 |=> chroma_lines == 3'h3;
   endproperty
   a_adapt_lines: assert property (p_adapt_lines) else $error("adaptive line count wrong");

   property p_chroma_off;
      @(posedge clk) disable iff (!rstn)
         line_start && c_mode == LPDC_CM_OFF |=> chroma_comb_off && chroma_lines == 3'h0;
   endproperty
   a_chroma_off: assert property (p_chroma_off) else $error("chroma comb not off");

   property p_luma_fixed;
      @(posedge clk) disable iff (!rstn)
         line_start && nycm_q == LPDC_CM_ALL |=> luma_lines == 3'h3 && !luma_adaptive;
   endproperty
   a_luma_fixed: assert property (p_luma_fixed) else $error("luma fixed comb wrong");

   property p_unity;
      @(posedge clk) disable iff (!rstn)
         !nren_q && peak_q == LPDC_UNITY && in_valid ##1 in_valid ##1 in_valid
         |=> out_luma == $past(in_luma, 3);
   endproperty
   a_unity: assert property (p_unity) else $error("unity gain altered luma");
endmodule
`default_nettype wire

//--- testbench/lpdc_video_src.sv
// Purpose: Behavioural composite video source feeding digitised luma and line starts
// Assumes: Everything is launched just after the rising edge of clk
// Notes:   Between samples the data bus shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module lpdc_video_src (
   input  wire logic  clk,
   output logic       in_valid,
   output logic [7:0] in_luma,
   output logic       line_start,
   output logic [3:0] video_std
);
   initial begin
      in_valid   = 1'b0;
      in_luma    = 8'h00;
      line_start = 1'b0;
      video_std  = 4'h0;
   end
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   // Back-to-back calls keep the stream continuous
   task automatic sample(input logic [7:0] v);
      tick();
      in_valid = 1'b1;
      in_luma  = v;
   endtask
   // Stale data is inverted so nothing can lean on a held value
   task automatic idle();
      tick();
      in_valid = 1'b0;
      in_luma  = ~in_luma;
   endtask
   // Standard only changes together with a line start
   task automatic new_line(input logic [3:0] s);
      tick();
      video_std  = s;
      line_start = 1'b1;
      tick();
      line_start = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: Self-checking bench for peaking, noise stage and comb configuration
// Assumes: Source model drives the stream side, bench drives the register port
// Notes:   Drivers queue expectations; a negedge monitor checks them in order
`timescale 1ns/1ps
`default_nettype none
module testbench
   import lpdc_pkg::*;
();
   logic        clk;
   logic        rstn;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic [3:0]  video_std;
   logic        line_start;
   logic        in_valid;
   logic [7:0]  in_luma;
   logic [7:0]  out_luma;
   logic        out_valid;
   logic [16:0] cvec;
   logic        cchk;
   logic        rd_n;
   logic        ls_n;
   logic [33:0] ce;
   logic [8:0]  le;
   logic [7:0]  re;
   logic [33:0] cq[$];
   logic [8:0]  lq[$];
   logic [7:0]  rq[$];
   logic [16:0] pe;
   logic [16:0] pm;
   logic [31:0] seed_v;
   logic [2:0]  modes[5];
   int          error_cnt = 0;
   int          total_checks = 0;
   int          cyc = 0;

   lpdc_video_src src (.clk(clk), .in_valid(in_valid), .in_luma(in_luma),
      .line_start(line_start), .video_std(video_std));
   lpdc_top #(.W(8)) dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .video_std(video_std), .line_start(line_start), .in_valid(in_valid),
      .in_luma(in_luma), .out_luma(out_luma), .out_valid(out_valid),
      .comb_is_pal(cvec[16]), .split_sel(cvec[15:14]), .chroma_lines(cvec[13:11]),
      .chroma_adaptive(cvec[10]), .chroma_comb_off(cvec[9]), .chroma_line_sel(cvec[8:7]),
      .luma_lines(cvec[6:4]), .luma_adaptive(cvec[3]), .luma_comb_off(cvec[2]),
      .luma_line_sel(cvec[1:0]));

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   task automatic conclude();
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc >= 5000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic cmp(input logic [16:0] e, input logic [16:0] a, input logic [16:0] m);
      total_checks++;
      if ((a & m) !== (e & m)) begin
         error_cnt++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e & m, a & m);
      end
   endtask
   // ------------------------------------------------------------
   // Monitor: an empty queue yields unknown, which always mismatches
   // ------------------------------------------------------------
   always @(negedge clk) begin
      if (rd_n) begin
         re = (rq.size() > 0) ? rq.pop_front() : 'x;
         cmp({9'h000, re}, {9'h000, reg_rdata}, 17'h000FF);
      end
      if (ls_n || cchk) begin
         ce = (cq.size() > 0) ? cq.pop_front() : 'x;
         cmp(ce[16:0], cvec, ce[33:17]);
      end
      if (out_valid) begin
         le = (lq.size() > 0) ? lq.pop_front() : 'x;
         if (le[8] !== 1'b0) cmp({9'h000, le[7:0]}, {9'h000, out_luma}, 17'h000FF);
      end
      rd_n = reg_rd;
      ls_n = line_start;
   end
   // ------------------------------------------------------------
   // Drivers
   // ------------------------------------------------------------
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick();
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      tick();
      reg_wr    = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rq.push_back(e);
      tick();
      reg_rd   = 1'b1;
      reg_addr = a;
      tick();
      reg_rd   = 1'b0;
   endtask
   task automatic chk_now(input logic [16:0] e, input logic [16:0] m);
      cq.push_back({m, e});
      tick();
      cchk = 1'b1;
      tick();
      cchk = 1'b0;
   endtask
   function automatic logic [2:0] cl_lines(input logic [2:0] c, input logic [1:0] t);
      if (c == LPDC_CM_OFF) return 3'h0;
      if (c == LPDC_CM_TOP || c == LPDC_CM_BOTTOM) return 3'(t) + 3'h1;
      return 3'(t) + 3'h2;
   endfunction
   function automatic logic [1:0] sel(input logic [2:0] c);
      return (c == LPDC_CM_TOP) ? 2'h1 : (c == LPDC_CM_BOTTOM) ? 2'h2 : 2'h0;
   endfunction
   task automatic comb_case(input int i);
      logic [1:0]  nsf, psf, nt, pt, t, sp;
      logic [2:0]  nc, pc, ny, c;
      logic [3:0]  s;
      logic        pal;
      logic [16:0] e, m;
      nsf = 2'($urandom);
      psf = 2'($urandom);
      nt  = 2'(1 + i % 3);
      pt  = 2'(1 + (i + 2) % 3);
      nc  = modes[i % 5];
      pc  = modes[(i + 1) % 5];
      ny  = modes[(i + 2) % 5];
      s   = 4'(i % 7);
      pal = (s >= 4'h2);
      t   = pal ? pt : nt;
      c   = pal ? pc : nc;
      sp  = pal ? psf : nsf;
      wr(LPDC_OFS_SPLIT, {4'h0, nsf, psf});
      wr(LPDC_OFS_NCOMB, {nt, nc, ny});
      wr(LPDC_OFS_PCOMB, {pt, pc, 3'h0});
      chk_now(pe, pm);
      e = {pal, sp, cl_lines(c, t), c == LPDC_CM_ADAPT, c == LPDC_CM_OFF, sel(c),
           (ny == LPDC_CM_TOP || ny == LPDC_CM_BOTTOM) ? 3'h2 : 3'h3,
           ny == LPDC_CM_ADAPT, ny == LPDC_CM_OFF, sel(ny)};
      m = 17'h1FFFF;
      if (c < LPDC_CM_TOP) m[8:7] = 2'h0;
      if (c == LPDC_CM_OFF) m[13:11] = 3'h0;
      if (ny < LPDC_CM_TOP) m[1:0] = 2'h0;
      if (ny == LPDC_CM_OFF) m[6:4] = 3'h0;
      cq.push_back({m, e});
      src.new_line(s);
      pe = e;
      pm = m;
   endtask
   // First skip and last tail samples see neighbours from other runs and go unchecked
   task automatic run(input int n, input int skip, input int tail, input logic [7:0] v,
                      input logic [7:0] ev, input logic rnd);
      logic [7:0] x;
      for (int k = 0; k < n; k++) begin
         x = rnd ? 8'($urandom) : v;
         lq.push_back({(k >= skip && k < n - tail) ? 1'b1 : 1'b0, rnd ? x : ev});
         src.sample(x);
      end
      src.idle();
   endtask
   // Quarter-rate tone: peaks and troughs move by the raw gain excess over 0x40, crossings stay
   task automatic tone(input logic [7:0] hi, input logic [7:0] lo);
      logic [7:0] x;
      logic [7:0] ev;
      for (int k = 0; k < 16; k++) begin
         x  = (k % 4 == 0) ? 8'hA0 : (k % 4 == 2) ? 8'h60 : 8'h80;
         ev = (k % 4 == 0) ? hi : (k % 4 == 2) ? lo : 8'h80;
         lq.push_back({(k >= 2 && k < 14) ? 1'b1 : 1'b0, ev});
         src.sample(x);
      end
      src.idle();
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rstn      = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      cchk      = 1'b0;
      rd_n      = 1'b0;
      ls_n      = 1'b0;
      pe        = 17'h00000;
      pm        = 17'h1FFFF;
      modes     = '{LPDC_CM_ADAPT, LPDC_CM_OFF, LPDC_CM_TOP, LPDC_CM_ALL, LPDC_CM_BOTTOM};
      seed_v    = $urandom(32'h9d0d2ac8);
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      rd(LPDC_OFS_SPLIT, 8'h01);
      rd(LPDC_OFS_NCOMB, 8'h80);
      rd(LPDC_OFS_PCOMB, 8'hC0);
      rd(LPDC_OFS_NREN, 8'h20);
      rd(LPDC_OFS_PEAK, 8'h40);
      rd(LPDC_OFS_NTH2, 8'h04);
      wr(8'h00, 8'hFF);
      rd(8'h00, 8'h00);
      chk_now(17'h00000, 17'h1FFFF);
      // Tap code 00 is refused while the other fields of the byte land
      wr(LPDC_OFS_NCOMB, 8'h2E);
      rd(LPDC_OFS_NCOMB, 8'hAE);
      wr(LPDC_OFS_PCOMB, 8'h2F);
      rd(LPDC_OFS_PCOMB, 8'hE8);
      for (int i = 0; i < 10; i++) comb_case(i);
      wr(LPDC_OFS_NREN, 8'h00);
      run(40, 0, 2, 8'h00, 8'h00, 1'b1);
      wr(LPDC_OFS_PEAK, 8'($urandom));
      run(20, 6, 2, 8'h80, 8'h80, 1'b0);
      wr(LPDC_OFS_PEAK, 8'h50);
      tone(8'hB0, 8'h50);
      wr(LPDC_OFS_PEAK, 8'h30);
      tone(8'h90, 8'h70);
      wr(LPDC_OFS_PEAK, 8'h40);
      wr(LPDC_OFS_NREN, 8'h20);
      run(8, 8, 0, 8'h80, 8'h80, 1'b0);
      run(8, 0, 0, 8'h84, 8'h80, 1'b0);
      run(8, 0, 0, 8'hA0, 8'hA0, 1'b0);
      wr(LPDC_OFS_NTH2, 8'h30);
      run(8, 0, 0, 8'hC0, 8'hA0, 1'b0);
      repeat (6) tick();
      conclude();
   end
endmodule
`default_nettype wire
